// ### regulator_event_status_regs_tb.sv
// self-checking bench for the event and status register group
`timescale 1ns/1ns
`default_nettype none
module regulator_event_status_regs_tb;
  typedef struct packed {
    resr_pkg::resr_top_in_s top;
    resr_pkg::resr_reg_in_s r0;
    resr_pkg::resr_reg_in_s r1;
    logic [7:0] ts;
    logic [7:0] rs;
  } resr_row_s;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  resr_pkg::resr_reg_in_s i_reg0 = '0;
  resr_pkg::resr_reg_in_s i_reg1 = '0;
  resr_pkg::resr_top_in_s i_top = '0;
  logic wr_en, rd_en, o_event_summary, o_irq;
  logic [7:0] addr, wdata, o_rdata;
  int n_errors = 0;
  int n_checks = 0;
  resr_row_s rows [8];
  resr_regs DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg0(i_reg0), .i_reg1(i_reg1),
    .i_top(i_top), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(o_rdata), .o_event_summary(o_event_summary), .o_irq(o_irq));
  resr_host_model host (.i_clock(i_clock), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(o_rdata));
  initial begin
    forever #20 i_clock = ~i_clock;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask
  // apply raw levels, then let synchronisers and filters settle
  task automatic drive(input resr_pkg::resr_top_in_s t, input resr_pkg::resr_reg_in_s a,
                       input resr_pkg::resr_reg_in_s b, input int n);
    @(posedge i_clock);
    i_top <= t;
    i_reg0 <= a;
    i_reg1 <= b;
    repeat (n) @(posedge i_clock);
  endtask
  initial begin
    repeat (60000) @(posedge i_clock);
    n_errors++;
    $display("[ERR] %0t run did not complete", $time);
    finish_test();
  end
  initial begin
    rows[0] = '{5'h10, 5'h00, 5'h00, 8'h80, 8'h00};
    rows[1] = '{5'h08, 5'h00, 5'h00, 8'h10, 8'h00};
    rows[2] = '{5'h04, 5'h00, 5'h00, 8'h08, 8'h00};
    rows[3] = '{5'h02, 5'h00, 5'h00, 8'h04, 8'h00};
    rows[4] = '{5'h01, 5'h00, 5'h00, 8'h02, 8'h00};
    rows[5] = '{5'h00, 5'h10, 5'h08, 8'h00, 8'h48};
    rows[6] = '{5'h00, 5'h08, 5'h04, 8'h00, 8'h14};
    rows[7] = '{5'h00, 5'h04, 5'h10, 8'h00, 8'h81};
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    rc(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h00);
    rc(8'h1D, 8'h00);
    rc(8'h1E, 8'h00);
    foreach (rows[i]) begin
      drive(rows[i].top, rows[i].r0, rows[i].r1, 10);
      rc(8'h1D, rows[i].ts);
      rc(8'h1E, rows[i].rs);
    end
    drive('0, '0, '0, 10);
    rc(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h11);
    chk({6'h00, o_event_summary, o_irq}, 8'h03);
    host.wr(resr_pkg::REG_EVENT_MASK_OFS, 8'h11);
    @(negedge i_clock);
    chk({6'h00, o_event_summary, o_irq}, 8'h02);
    rc(resr_pkg::REG_EVENT_MASK_OFS, 8'h11);
    rc(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h11);
    host.wr(resr_pkg::REG_EVENT_MASK_OFS, 8'h00);
    // power-good events held five cycles, then released
    drive('0, 5'h01, 5'h01, 4);
    drive('0, '0, '0, 10);
    rc(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h55);
    host.wr(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h00);
    host.wr(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h88);
    rc(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h55);
    host.wr(8'h1D, 8'hFF);
    rc(8'h1D, 8'h00);
    rc(8'h40, 8'h00);
    drive('0, 5'h04, '0, 10);
    host.wr(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h55);
    rc(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h01);
    drive('0, '0, '0, 10);
    host.wr(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h01);
    rc(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h00);
    chk({7'h00, o_event_summary}, 8'h00);
    // both outputs below the short threshold: just under and just over the time
    drive('0, 5'h02, 5'h02, 24000);
    rc(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h00);
    repeat (1100) @(posedge i_clock);
    rc(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h22);
    host.wr(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h22);
    rc(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h22);
    // reset in mid-run with a short still present
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    chk(o_rdata, 8'h00);
    chk({6'h00, o_event_summary, o_irq}, 8'h00);
    @(posedge i_clock);
    i_sys_rst <= 1'b0;
    rc(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h00);
    drive('0, '0, '0, 10);
    host.wr(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h22);
    rc(resr_pkg::REG_EVENT_FLAGS_OFS, 8'h00);
    finish_test();
  end
endmodule // regulator_event_status_regs_tb
`default_nettype wire

// ### resr_host_model.sv
// host-side register access model for the event and status registers
`timescale 1ns/1ns
`default_nettype none
module resr_host_model (
  // clock
  input wire logic i_clock,
  // register access port towards the device
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // one-cycle strobe per byte, launched just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_wr_en <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clock);
    o_wr_en <= 1'b0;
    o_wdata <= ~d;
    @(posedge i_clock);
  endtask
  // read data is sampled after the edge following the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_rd_en <= 1'b1;
    o_addr <= a;
    @(posedge i_clock);
    o_rd_en <= 1'b0;
    @(posedge i_clock);
    @(negedge i_clock);
    d = i_rdata;
  endtask
endmodule // resr_host_model
`default_nettype wire

// ### resr_pkg.sv
// package for the regulator event and status register group
package resr_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] TOP_LIVE_STATUS_OFS = 8'h1D;
  localparam logic [7:0] REG_LIVE_STATUS_OFS = 8'h1E;
  localparam logic [7:0] REG_EVENT_FLAGS_OFS = 8'h1B;
  localparam logic [7:0] REG_EVENT_MASK_OFS = 8'h22;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int EV_REG0_CURLIMIT = 0;
  localparam int EV_REG0_SHORT = 1;
  localparam int EV_REG0_POWERGOOD = 2;
  localparam int EV_REG1_CURLIMIT = 4;
  localparam int EV_REG1_SHORT = 5;
  localparam int EV_REG1_POWERGOOD = 6;
  localparam logic [7:0] EV_USED_MASK = 8'h77;
  localparam int TS_POWERGOOD = 7;
  localparam int TS_SYNC_INVALID = 4;
  localparam int TS_THERMAL_SD = 3;
  localparam int TS_THERMAL_WARN = 2;
  localparam int TS_OVERVOLT = 1;
  localparam int RS_REG1_ENABLED = 7;
  localparam int RS_REG1_INVALID = 6;
  localparam int RS_REG1_CURLIMIT = 4;
  localparam int RS_REG0_ENABLED = 3;
  localparam int RS_REG0_INVALID = 2;
  localparam int RS_REG0_CURLIMIT = 0;
  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] EVENT_FLAGS_RST = 8'h00;
  localparam logic [7:0] EVENT_MASK_RST = 8'h00;
  localparam int CLOCK_HZ = 25_000_000;
  localparam int SHORT_TIME_US = 1000;
  localparam int SHORT_CYCLES = (CLOCK_HZ / 1_000_000) * SHORT_TIME_US + 1;
  localparam int SYNC_STAGES = 3;

  // per-regulator raw inputs
  typedef struct packed {
    logic enabled;
    logic output_invalid;
    logic curlimit;
    logic below_short;
    logic powergood_event;
  } resr_reg_in_s;

  // device-level raw inputs
  typedef struct packed {
    logic power_good_pin;
    logic sync_invalid;
    logic thermal_sd;
    logic thermal_warn;
    logic overvolt;
  } resr_top_in_s;
endpackage

// ### resr_regs.sv
// regulator event flags, live status registers and event summary
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - reg1 power-good event latches bit 6; only a written 1 clears it.
// - reg1 output below short threshold over 1 ms latches bit 5; W1C.
// - reg1 current limiting active latches bit 4; W1C.
// - reg0 power-good event latches bit 2; only a written 1 clears it.
// - reg0 output below short threshold over 1 ms latches bit 1; W1C.
// - reg0 current limiting active latches bit 0; W1C.
// - top status bit 7 follows power-good pin live.
// - top status bit 4 reads 1 while external sync clock is invalid.
// - top status bit 3 reads 1 while above thermal shutdown.
// - top status bit 2 reads 1 while above thermal warning.
// - top status bit 1 reads 1 while input overvoltage present.
// - regulator status bit 7 reads reg1 enabled.
// - regulator status bit 6 reads reg1 output invalid, unlatched.
// - regulator status bit 4 reads reg1 current limit, unlatched.
// - regulator status bit 3 reads reg0 enabled.
// - regulator status bit 2 reads reg0 output invalid, unlatched.
// - regulator status bit 0 reads reg0 current limit, unlatched.
// - summary flag is set while any event bit set, clears at zero.
// - mask 0 lets event reach interrupt, 1 suppresses; status unchanged.
module resr_regs (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // raw monitor inputs from the analog side
  input wire resr_pkg::resr_reg_in_s i_reg0,
  input wire resr_pkg::resr_reg_in_s i_reg1,
  input wire resr_pkg::resr_top_in_s i_top,
  // register access port
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // summary and interrupt
  output logic o_event_summary,
  output logic o_irq
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int NIN = 15;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1_r;
  logic [NIN-1:0] sync2_r;
  logic [NIN-1:0] sync3_r;
  logic [NIN-1:0] clean_r;
  assign raw_in = {i_reg1, i_reg0, i_top};

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // a change is taken once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_filt
      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          clean_r[gi] <= 1'b0;
        end else if (sync2_r[gi] == sync3_r[gi]) begin
          clean_r[gi] <= sync3_r[gi];
        end
      end
    end
  endgenerate

  resr_pkg::resr_top_in_s top_c;
  resr_pkg::resr_reg_in_s reg0_c;
  resr_pkg::resr_reg_in_s reg1_c;
  assign {reg1_c, reg0_c, top_c} = clean_r;

  // ---------------------------------------------------------------
  // short-circuit duration timers
  // ---------------------------------------------------------------
  localparam int SCW = $clog2(resr_pkg::SHORT_CYCLES + 1);
  localparam logic [SCW-1:0] SC_LIMIT = SCW'(resr_pkg::SHORT_CYCLES);
  logic [SCW-1:0] sc_cnt_r [2];
  logic [1:0] short_hit;
  logic [1:0] below;
  assign below = {reg1_c.below_short, reg0_c.below_short};

  generate
    for (gi = 0; gi < 2; gi++) begin : g_sc
      // counts while below threshold, saturates past 1 ms
      always_ff @(posedge i_clock) begin
        if (i_sys_rst || !below[gi]) begin
          sc_cnt_r[gi] <= '0;
        end else if (sc_cnt_r[gi] != SC_LIMIT) begin
          sc_cnt_r[gi] <= sc_cnt_r[gi] + SCW'(1);
        end
      end
      assign short_hit[gi] = (sc_cnt_r[gi] == SC_LIMIT);
    end
  endgenerate

  // ---------------------------------------------------------------
  // event flags and mask
  // ---------------------------------------------------------------
  logic [7:0] ev_flags_r;
  logic [7:0] ev_mask_r;
  logic [7:0] ev_set;
  logic [7:0] ev_clr;
  logic wr_flags;
  logic wr_mask;

  assign wr_flags = i_wr_en && (i_addr == resr_pkg::REG_EVENT_FLAGS_OFS);
  assign wr_mask = i_wr_en && (i_addr == resr_pkg::REG_EVENT_MASK_OFS);

  always_comb begin
    ev_set = 8'h00;
    ev_set[resr_pkg::EV_REG1_POWERGOOD] = reg1_c.powergood_event;
    ev_set[resr_pkg::EV_REG1_SHORT] = short_hit[1];
    ev_set[resr_pkg::EV_REG1_CURLIMIT] = reg1_c.curlimit;
    ev_set[resr_pkg::EV_REG0_POWERGOOD] = reg0_c.powergood_event;
    ev_set[resr_pkg::EV_REG0_SHORT] = short_hit[0];
    ev_set[resr_pkg::EV_REG0_CURLIMIT] = reg0_c.curlimit;
  end

  // writing 1 clears, writing 0 leaves the bit alone
  assign ev_clr = wr_flags ? i_wdata : 8'h00;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ev_flags_r <= resr_pkg::EVENT_FLAGS_RST;
    end else begin
      // set wins over clear; reserved bits stay zero
      ev_flags_r <= ((ev_flags_r & ~ev_clr) | ev_set) & resr_pkg::EV_USED_MASK;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ev_mask_r <= resr_pkg::EVENT_MASK_RST;
    end else if (wr_mask) begin
      ev_mask_r <= i_wdata & resr_pkg::EV_USED_MASK;
    end
  end

  assign o_event_summary = |ev_flags_r;
  assign o_irq = |(ev_flags_r & ~ev_mask_r);

  // ---------------------------------------------------------------
  // live status and read mux
  // ---------------------------------------------------------------
  logic [7:0] top_stat;
  logic [7:0] reg_stat;

  always_comb begin
    top_stat = 8'h00;
    top_stat[resr_pkg::TS_POWERGOOD] = top_c.power_good_pin;
    top_stat[resr_pkg::TS_SYNC_INVALID] = top_c.sync_invalid;
    top_stat[resr_pkg::TS_THERMAL_SD] = top_c.thermal_sd;
    top_stat[resr_pkg::TS_THERMAL_WARN] = top_c.thermal_warn;
    top_stat[resr_pkg::TS_OVERVOLT] = top_c.overvolt;
    reg_stat = 8'h00;
    reg_stat[resr_pkg::RS_REG1_ENABLED] = reg1_c.enabled;
    reg_stat[resr_pkg::RS_REG1_INVALID] = reg1_c.output_invalid;
    reg_stat[resr_pkg::RS_REG1_CURLIMIT] = reg1_c.curlimit;
    reg_stat[resr_pkg::RS_REG0_ENABLED] = reg0_c.enabled;
    reg_stat[resr_pkg::RS_REG0_INVALID] = reg0_c.output_invalid;
    reg_stat[resr_pkg::RS_REG0_CURLIMIT] = reg0_c.curlimit;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd_en) begin
      unique case (i_addr)
        resr_pkg::TOP_LIVE_STATUS_OFS: o_rdata <= top_stat;
        resr_pkg::REG_LIVE_STATUS_OFS: o_rdata <= reg_stat;
        resr_pkg::REG_EVENT_FLAGS_OFS: o_rdata <= ev_flags_r;
        resr_pkg::REG_EVENT_MASK_OFS: o_rdata <= ev_mask_r;
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertion helpers
  // ---------------------------------------------------------------
  // cycles each filtered short input has stayed high, counted apart
  // from the timers so the timing checks do not lean on them
  localparam logic [15:0] RUN_MIN = 16'(resr_pkg::SHORT_CYCLES);
  logic [15:0] below_run_r [2];

  generate
    for (gi = 0; gi < 2; gi++) begin : g_run
      always_ff @(posedge i_clock) begin
        if (i_sys_rst || !below[gi]) begin
          below_run_r[gi] <= 16'h0000;
        end else if (below_run_r[gi] != 16'hFFFF) begin
          below_run_r[gi] <= below_run_r[gi] + 16'h0001;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  rg1_pg_latch_a: assert property (reg1_c.powergood_event |=> ev_flags_r[6])
    else $error("reg1 power-good event not latched");
  rg1_pg_hold_a: assert property (ev_flags_r[6] && !(wr_flags && i_wdata[6]) |=> ev_flags_r[6])
    else $error("reg1 power-good flag lost without clear");
  rg1_short_a: assert property ($rose(short_hit[1]) |-> $past(reg1_c.below_short, 8))
    else $error("reg1 short flagged too early");
  rg0_short_a: assert property ($rose(ev_flags_r[resr_pkg::EV_REG0_SHORT])
    |-> $past(below_run_r[0]) >= RUN_MIN)
    else $error("reg0 short flag set before 1 ms");
  rg1_ilim_a: assert property (reg1_c.curlimit |=> ev_flags_r[4])
    else $error("reg1 current limit not latched");
  rg0_pg_latch_a: assert property (reg0_c.powergood_event |=> ev_flags_r[2])
    else $error("reg0 power-good event not latched");
  rg0_ilim_a: assert property (reg0_c.curlimit |=> ev_flags_r[0])
    else $error("reg0 current limit not latched");
  w1c_clear_a: assert property (wr_flags && i_wdata[0] && !reg0_c.curlimit |=> !ev_flags_r[0])
    else $error("write one did not clear flag");
  rsvd_zero_a: assert property (ev_flags_r[7] == 1'b0 && ev_flags_r[3] == 1'b0)
    else $error("reserved event bit set");
  summary_a: assert property ((ev_flags_r == 8'h00) == !o_event_summary)
    else $error("summary flag mismatch");
  mask_a: assert property ((ev_flags_r & ~ev_mask_r) == 8'h00 |-> !o_irq)
    else $error("masked event raised interrupt");
  rd_top_a: assert property (i_rd_en && i_addr == resr_pkg::TOP_LIVE_STATUS_OFS |=> o_rdata[7] == $past(top_c.power_good_pin))
    else $error("top status read wrong");
  rd_reg_a: assert property (i_rd_en && i_addr == resr_pkg::REG_LIVE_STATUS_OFS |=> o_rdata[6] == $past(reg1_c.output_invalid) && o_rdata[0] == $past(reg0_c.curlimit))
    else $error("regulator status read wrong");


  // ---------------------------------------------------------------
  // filter and timer checks
  // ---------------------------------------------------------------
  sync_shift_a: assert property (sync2_r == $past(sync1_r))
    else $error("synchroniser stage skipped");
  filt_agree_a: assert property (sync2_r == sync3_r |=> clean_r == $past(sync3_r))
    else $error("filter did not take agreed input");
  rg1_short_time_a: assert property ($rose(ev_flags_r[resr_pkg::EV_REG1_SHORT])
    |-> $past(below_run_r[1]) >= RUN_MIN)
    else $error("reg1 short flag set before 1 ms");
  rg1_short_set_a: assert property (below_run_r[1] == RUN_MIN |=> ev_flags_r[5])
    else $error("reg1 short flag missed after 1 ms");
  rg0_short_set_a: assert property (below_run_r[0] == RUN_MIN |=> ev_flags_r[1])
    else $error("reg0 short flag missed after 1 ms");

  // ---------------------------------------------------------------
  // flag clear and reserved mask checks
  // ---------------------------------------------------------------
  // a clear only lands when no event holds the bit in that cycle
  rg0_pg_hold_a: assert property (ev_flags_r[2] && !(wr_flags && i_wdata[2]) |=> ev_flags_r[2])
    else $error("reg0 power-good flag lost without clear");
  rg1_pg_clr_a: assert property (wr_flags && i_wdata[6] && !reg1_c.powergood_event |=> !ev_flags_r[6])
    else $error("reg1 power-good flag not cleared");
  rg0_pg_clr_a: assert property (wr_flags && i_wdata[2] && !reg0_c.powergood_event |=> !ev_flags_r[2])
    else $error("reg0 power-good flag not cleared");
  rg1_ilim_clr_a: assert property (wr_flags && i_wdata[4] && !reg1_c.curlimit |=> !ev_flags_r[4])
    else $error("reg1 current limit flag not cleared");
  rg1_sc_clr_a: assert property (wr_flags && i_wdata[5] && !short_hit[1] |=> !ev_flags_r[5])
    else $error("reg1 short flag not cleared");
  rg0_sc_clr_a: assert property (wr_flags && i_wdata[1] && !short_hit[0] |=> !ev_flags_r[1])
    else $error("reg0 short flag not cleared");
  w1c_keep_a: assert property (wr_flags && ev_flags_r[4] && !i_wdata[4] |=> ev_flags_r[4])
    else $error("write zero changed flag");
  w1c_keep0_a: assert property (wr_flags && ev_flags_r[0] && !i_wdata[0] |=> ev_flags_r[0])
    else $error("write zero changed flag");
  rsvd_mask_a: assert property (ev_mask_r[7] == 1'b0 && ev_mask_r[3] == 1'b0)
    else $error("reserved mask bit set");

  // ---------------------------------------------------------------
  // mask and event read checks
  // ---------------------------------------------------------------
  irq_unmask_a: assert property ((ev_flags_r & ~ev_mask_r) != 8'h00 |-> o_irq)
    else $error("unmasked event gave no interrupt");
  mask_wr_a: assert property (wr_mask
    |=> ev_mask_r == ($past(i_wdata) & resr_pkg::EV_USED_MASK))
    else $error("mask write not stored");
  rd_flags_a: assert property (i_rd_en && i_addr == resr_pkg::REG_EVENT_FLAGS_OFS
    |=> o_rdata == $past(ev_flags_r))
    else $error("event flag read wrong");
  rd_unmapped_a: assert property (i_rd_en && i_addr > resr_pkg::REG_EVENT_MASK_OFS
    |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");

  // ---------------------------------------------------------------
  // live status read checks
  // ---------------------------------------------------------------
  // every read returns the filtered level of the cycle it was taken in
  rd_sync_a: assert property (i_rd_en && i_addr == resr_pkg::TOP_LIVE_STATUS_OFS
    |=> o_rdata[resr_pkg::TS_SYNC_INVALID] == $past(top_c.sync_invalid))
    else $error("sync status read wrong");
  rd_tsd_a: assert property (i_rd_en && i_addr == resr_pkg::TOP_LIVE_STATUS_OFS
    |=> o_rdata[resr_pkg::TS_THERMAL_SD] == $past(top_c.thermal_sd))
    else $error("thermal shutdown read wrong");
  rd_twarn_a: assert property (i_rd_en && i_addr == resr_pkg::TOP_LIVE_STATUS_OFS
    |=> o_rdata[resr_pkg::TS_THERMAL_WARN] == $past(top_c.thermal_warn))
    else $error("thermal warning read wrong");
  rd_ovp_a: assert property (i_rd_en && i_addr == resr_pkg::TOP_LIVE_STATUS_OFS
    |=> o_rdata[resr_pkg::TS_OVERVOLT] == $past(top_c.overvolt))
    else $error("overvoltage read wrong");
  rd_rsvd_a: assert property (i_rd_en && i_addr == resr_pkg::TOP_LIVE_STATUS_OFS
    |=> o_rdata[6:5] == 2'b00 && o_rdata[0] == 1'b0)
    else $error("top status reserved bit set");
  rd_en1_a: assert property (i_rd_en && i_addr == resr_pkg::REG_LIVE_STATUS_OFS
    |=> o_rdata[resr_pkg::RS_REG1_ENABLED] == $past(reg1_c.enabled))
    else $error("reg1 enable read wrong");
  rd_en0_a: assert property (i_rd_en && i_addr == resr_pkg::REG_LIVE_STATUS_OFS
    |=> o_rdata[resr_pkg::RS_REG0_ENABLED] == $past(reg0_c.enabled))
    else $error("reg0 enable read wrong");
  rd_ilim1_a: assert property (i_rd_en && i_addr == resr_pkg::REG_LIVE_STATUS_OFS
    |=> o_rdata[resr_pkg::RS_REG1_CURLIMIT] == $past(reg1_c.curlimit))
    else $error("reg1 current limit read wrong");
  rd_inv0_a: assert property (i_rd_en && i_addr == resr_pkg::REG_LIVE_STATUS_OFS
    |=> o_rdata[resr_pkg::RS_REG0_INVALID] == $past(reg0_c.output_invalid))
    else $error("reg0 output validity read wrong");
  rd_rs_rsvd_a: assert property (i_rd_en && i_addr == resr_pkg::REG_LIVE_STATUS_OFS
    |=> o_rdata[5] == 1'b0 && o_rdata[1] == 1'b0)
    else $error("regulator status reserved bit set");

  pg_cov_c: cover property (reg0_c.powergood_event ##1 ev_flags_r[2]);
  clear_cov_c: cover property (ev_flags_r[5] ##1 wr_flags && i_wdata[5] ##1 !ev_flags_r[5]);
  reset_sum_c: cover property (o_event_summary ##1 !o_event_summary);
  irq_cov_c: cover property (o_irq);
  short_cov_c: cover property ($rose(short_hit[0]));

endmodule // resr_regs

`default_nettype wire
